// ===== hw/ifd_pkg.sv
package ifd_pkg;

  // ----------------------------------------------------------------
  // word layout, bit 0 is the most significant bit
  // ----------------------------------------------------------------
  localparam int IFD_WORD_W = 24;
  localparam int IFD_ADDR_W = 14;
  localparam int IFD_MADDR_W = 15;
  localparam int IFD_OP_W = 7;
  localparam int IFD_BANK_W = 3;
  localparam int IFD_POS_RELOC = 0;
  localparam int IFD_POS_INDEX = 1;
  localparam int IFD_POS_OP_FIRST = 2;
  localparam int IFD_POS_OP_LAST = 8;
  localparam int IFD_POS_POP = 2;
  localparam int IFD_POS_INDIRECT = 9;
  localparam int IFD_POS_ADDR_FIRST = 10;
  localparam int IFD_POS_ADDR_LAST = 23;
  localparam int IFD_POS_EXT = 10;
  localparam int IFD_POS_SIGN = 0;

  // ----------------------------------------------------------------
  // bank extension
  // ----------------------------------------------------------------
  localparam logic [1:0] IFD_SEL_UPPER = 2'b11;
  localparam logic [1:0] IFD_SEL_LOWER = 2'b10;
  localparam logic [2:0] IFD_UPPER_RESET = 3'h3;
  localparam logic [2:0] IFD_LOWER_RESET = 3'h2;

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] IFD_OFS_BANK = 8'h00;
  localparam logic [7:0] IFD_OFS_INDEX = 8'h04;
  localparam logic [7:0] IFD_OFS_STATUS = 8'h08;
  localparam logic [7:0] IFD_OFS_RESULT = 8'h0c;
  localparam logic [7:0] IFD_OFS_FIXED = 8'h10;
  localparam logic [7:0] IFD_OFS_FIXNEG = 8'h14;
  localparam int IFD_BANK_LOWER_LSB = 3;
  localparam int IFD_STAT_LEVELS_LSB = 8;
  localparam int IFD_STAT_OP_LSB = 16;
  localparam int IFD_RES_EA_LSB = 16;
  localparam logic [23:0] IFD_INDEX_RESET = 24'h00_0000;
  localparam logic [23:0] IFD_FIXED_RESET = 24'h00_0000;
  localparam logic [7:0] IFD_LEVELS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic [IFD_MADDR_W-1:0] addr;
  } ifd_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [IFD_OP_W-1:0] opcode;
    logic pop;
    logic [IFD_ADDR_W-1:0] eff_addr;
    logic [IFD_MADDR_W-1:0] mem_addr;
  } ifd_exec_t;

  // vector index of a documented bit position
  function automatic int ifd_bit(input int pos);
    return IFD_WORD_W - 1 - pos;
  endfunction : ifd_bit

endpackage : ifd_pkg

// ===== hw/ifd_addr_form.sv
`timescale 1ns/1ps
module ifd_addr_form
  import ifd_pkg::*;
(
  input wire logic [ifd_pkg::IFD_WORD_W-1:0] word,
  input wire logic [ifd_pkg::IFD_WORD_W-1:0] index_reg,
  input wire logic [ifd_pkg::IFD_BANK_W-1:0] upper_bank_extension,
  input wire logic [ifd_pkg::IFD_BANK_W-1:0] lower_bank_extension,
  output logic index_flag,
  output logic indirect_flag,
  output logic [ifd_pkg::IFD_ADDR_W-1:0] eff_addr,
  output logic [ifd_pkg::IFD_MADDR_W-1:0] mem_addr
);

  // ----------------------------------------------------------------
  // field split of an address word
  // ----------------------------------------------------------------
  wire logic [IFD_ADDR_W-1:0] addr_field;
  wire logic [IFD_ADDR_W-1:0] index_part;
  wire logic [IFD_BANK_W-1:0] bank_digit;
  wire logic ext_on;

  assign index_flag = word[ifd_bit(IFD_POS_INDEX)];
  assign indirect_flag = word[ifd_bit(IFD_POS_INDIRECT)];
  assign addr_field = word[ifd_bit(IFD_POS_ADDR_FIRST):0];
  assign index_part = index_reg[ifd_bit(IFD_POS_ADDR_FIRST):0];

  // pure add, no extra cycle; carry out of bit 13 dropped
  assign eff_addr = index_flag ? IFD_ADDR_W'(addr_field + index_part) : addr_field;

  // ----------------------------------------------------------------
  // bank extension select
  // ----------------------------------------------------------------
  assign ext_on = eff_addr[IFD_ADDR_W-1 - (IFD_POS_EXT - IFD_POS_ADDR_FIRST)];
  // 1,1 picks upper digit, 1,0 picks lower digit
  assign bank_digit = (eff_addr[IFD_ADDR_W-1:IFD_ADDR_W-2] == IFD_SEL_UPPER) ?
                      upper_bank_extension : lower_bank_extension;
  assign mem_addr = ext_on ? {bank_digit, eff_addr[IFD_ADDR_W-3:0]} :
                    {1'b0, eff_addr};

endmodule : ifd_addr_form

// ===== hw/ifd_decoder.sv
`timescale 1ns/1ps
module ifd_decoder
  import ifd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic operator_start,
  input wire logic fetch_req,
  input wire logic [ifd_pkg::IFD_MADDR_W-1:0] fetch_addr,
  output logic fetch_busy,
  output ifd_pkg::ifd_mem_req_t mem_out,
  input wire logic mem_ack,
  input wire logic [ifd_pkg::IFD_WORD_W-1:0] mem_rdata,
  output ifd_pkg::ifd_exec_t exec_out,
  output logic [ifd_pkg::IFD_BANK_W-1:0] upper_bank_extension,
  output logic [ifd_pkg::IFD_BANK_W-1:0] lower_bank_extension
);
  import ifd_pkg::*;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IFD_IDLE,
    IFD_FETCH_INSTR,
    IFD_FETCH_IND
  } ifd_state_t;

  ifd_state_t state;
  ifd_state_t next_state;
  logic [IFD_WORD_W-1:0] index_reg;
  logic [IFD_WORD_W-1:0] fixed_reg;
  logic [IFD_OP_W-1:0] op_hold;
  logic pop_hold;
  logic [7:0] levels;
  logic [7:0] next_levels;
  logic [IFD_MADDR_W-1:0] next_mem_addr;
  logic next_req;
  logic next_valid;

  // ----------------------------------------------------------------
  // decode of the fetched word
  // ----------------------------------------------------------------
  wire logic word_index;
  wire logic word_indirect;
  wire logic [IFD_ADDR_W-1:0] word_ea;
  wire logic [IFD_MADDR_W-1:0] word_maddr;
  wire logic [IFD_OP_W-1:0] word_op;
  wire logic word_pop;
  wire logic in_fetch;
  wire logic word_taken;
  wire logic take_instr;
  wire logic levels_full;

  // relocation bit never reaches any decode path
  assign word_op = mem_rdata[ifd_bit(IFD_POS_OP_FIRST):ifd_bit(IFD_POS_OP_LAST)];
  assign word_pop = mem_rdata[ifd_bit(IFD_POS_POP)];
  assign in_fetch = (state == IFD_FETCH_INSTR) || (state == IFD_FETCH_IND);
  assign word_taken = in_fetch && mem_ack;
  assign take_instr = word_taken && (state == IFD_FETCH_INSTR);
  // depth counter parks at its top rather than wrapping to zero
  assign levels_full = (levels == 8'hff);

  // same address former for instruction and every indirect level
  ifd_addr_form u_addr_form (
    .word(mem_rdata),
    .index_reg(index_reg),
    .upper_bank_extension(upper_bank_extension),
    .lower_bank_extension(lower_bank_extension),
    .index_flag(word_index),
    .indirect_flag(word_indirect),
    .eff_addr(word_ea),
    .mem_addr(word_maddr)
  );

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_req = mem_out.req;
    next_mem_addr = mem_out.addr;
    next_valid = 1'b0;
    next_levels = levels;
    unique case (state)
      IFD_IDLE: begin
        if (fetch_req) begin
          next_state = IFD_FETCH_INSTR;
          next_req = 1'b1;
          next_mem_addr = fetch_addr;
          next_levels = IFD_LEVELS_RESET;
        end
      end
      IFD_FETCH_INSTR, IFD_FETCH_IND: begin
        if (mem_ack) begin
          if (word_indirect) begin
            // one further memory cycle per level, request held high
            next_state = IFD_FETCH_IND;
            next_mem_addr = word_maddr;
            next_levels = levels_full ? levels : 8'(levels + 8'h01);
          end else begin
            next_state = IFD_IDLE;
            next_req = 1'b0;
            next_valid = 1'b1;
          end
        end
      end
      default: begin
        // stray state code: back to idle with the request dropped
        next_state = IFD_IDLE;
        next_req = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer registers; memory port is read only, word never written
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= IFD_IDLE;
      mem_out <= '0;
      levels <= IFD_LEVELS_RESET;
      fetch_busy <= 1'b0;
    end else begin
      state <= next_state;
      mem_out.req <= next_req;
      mem_out.addr <= next_mem_addr;
      levels <= next_levels;
      fetch_busy <= (next_state != IFD_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // opcode caught from the instruction only, not from address words
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_hold <= '0;
      pop_hold <= 1'b0;
    end else if (take_instr) begin
      op_hold <= word_op;
      pop_hold <= word_pop;
    end
  end

  // ----------------------------------------------------------------
  // hand-off to execution logic
  // ----------------------------------------------------------------
  wire logic final_from_instr;
  wire logic [IFD_OP_W-1:0] final_op;
  wire logic final_pop;

  // a chain of zero levels ends in the instruction's own cycle
  assign final_from_instr = (state == IFD_FETCH_INSTR);
  assign final_op = final_from_instr ? word_op : op_hold;
  assign final_pop = final_from_instr ? word_pop : pop_hold;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_out <= '0;
    end else begin
      exec_out.valid <= next_valid;
      if (next_valid) begin
        exec_out.opcode <= final_op;
        exec_out.pop <= final_pop;
        exec_out.eff_addr <= word_ea;
        exec_out.mem_addr <= word_maddr;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic apb_setup;
  wire logic apb_wr;
  wire logic hit_bank;
  wire logic hit_index;
  wire logic hit_status;
  wire logic hit_result;
  wire logic hit_fixed;
  wire logic hit_fixneg;
  wire logic hit_any;
  wire logic wr_bank;
  wire logic wr_index;
  wire logic wr_fixed;
  wire logic [IFD_BANK_W-1:0] wr_upper;
  wire logic [IFD_BANK_W-1:0] wr_lower;

  // one offset compare shared by every register select
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : reg_hit

  // a write lands only at the access edge that completes it
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && pready;
  assign hit_bank = reg_hit(paddr, IFD_OFS_BANK);
  assign hit_index = reg_hit(paddr, IFD_OFS_INDEX);
  assign hit_status = reg_hit(paddr, IFD_OFS_STATUS);
  assign hit_result = reg_hit(paddr, IFD_OFS_RESULT);
  assign hit_fixed = reg_hit(paddr, IFD_OFS_FIXED);
  assign hit_fixneg = reg_hit(paddr, IFD_OFS_FIXNEG);
  assign hit_any = hit_bank | hit_index | hit_status | hit_result | hit_fixed | hit_fixneg;

  // status, result and negation views are read only; writes fall away
  assign wr_bank = apb_wr && hit_bank;
  assign wr_index = apb_wr && hit_index;
  assign wr_fixed = apb_wr && hit_fixed;
  assign wr_upper = pwdata[IFD_BANK_W-1:0];
  assign wr_lower = pwdata[IFD_BANK_LOWER_LSB +: IFD_BANK_W];

  // ----------------------------------------------------------------
  // bank extension registers; operator start wins over a write
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_bank_extension <= IFD_UPPER_RESET;
      lower_bank_extension <= IFD_LOWER_RESET;
    end else if (operator_start) begin
      upper_bank_extension <= IFD_UPPER_RESET;
      lower_bank_extension <= IFD_LOWER_RESET;
    end else if (wr_bank) begin
      upper_bank_extension <= wr_upper;
      lower_bank_extension <= wr_lower;
    end
  end

  // ----------------------------------------------------------------
  // index and fixed-point operand registers
  // ----------------------------------------------------------------
  // whole word kept, though only the low 14 bits reach the adder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_reg <= IFD_INDEX_RESET;
    end else if (wr_index) begin
      index_reg <= pwdata[IFD_WORD_W-1:0];
    end
  end

  // upper eight bus bits dropped, a word is only 24 wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_reg <= IFD_FIXED_RESET;
    end else if (wr_fixed) begin
      fixed_reg <= pwdata[IFD_WORD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // fixed-point views: sign and two's complement negation
  // ----------------------------------------------------------------
  wire logic fixed_sign;
  wire logic [IFD_WORD_W-1:0] fixed_neg;
  wire logic fixed_neg_ovf;

  assign fixed_sign = fixed_reg[ifd_bit(IFD_POS_SIGN)];
  assign fixed_neg = IFD_WORD_W'(~fixed_reg + 24'h00_0001);
  // most negative value has no positive twin
  assign fixed_neg_ovf = fixed_sign && (fixed_neg == fixed_reg);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire logic [31:0] rd_bank;
  wire logic [31:0] rd_status;
  wire logic [31:0] rd_result;
  wire logic [31:0] rd_fixneg;
  wire logic [31:0] rd_mux;
  wire logic upper_lit;
  wire logic lower_lit;

  assign rd_bank = {26'h000_0000, lower_bank_extension, upper_bank_extension};
  // bits 1 and 2 light when a bank differs from its start value
  assign upper_lit = (upper_bank_extension != IFD_UPPER_RESET);
  assign lower_lit = (lower_bank_extension != IFD_LOWER_RESET);
  assign rd_status = {9'h000, exec_out.opcode, levels, 5'h00,
                      lower_lit, upper_lit, fetch_busy};
  assign rd_result = {1'b0, exec_out.eff_addr, 1'b0, exec_out.pop, exec_out.mem_addr};
  assign rd_fixneg = {6'h00, fixed_neg_ovf, fixed_sign, fixed_neg};
  assign rd_mux = hit_bank ? rd_bank :
                  hit_index ? {8'h00, index_reg} :
                  hit_status ? rd_status :
                  hit_result ? rd_result :
                  hit_fixed ? {8'h00, fixed_reg} :
                  hit_fixneg ? rd_fixneg : 32'h0000_0000;

  // ----------------------------------------------------------------
  // apb answer: zero wait, read data latched in the setup cycle
  // ----------------------------------------------------------------
  wire logic [31:0] next_prdata;
  wire logic next_pslverr;

  // writes answer zero, so no stale read data leaks onto the bus
  assign next_prdata = pwrite ? 32'h0000_0000 : rd_mux;
  assign next_pslverr = !hit_any;

  // ready from the first edge after reset and never lowered again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // caught at the setup edge; stands until the next setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : ifd_decoder

// ===== tb/ifd_checker.sv
`timescale 1ns/1ps
module ifd_checker
  import ifd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic operator_start,
  input wire logic fetch_req,
  input wire logic [ifd_pkg::IFD_MADDR_W-1:0] fetch_addr,
  input wire logic fetch_busy,
  input wire ifd_pkg::ifd_mem_req_t mem_out,
  input wire logic mem_ack,
  input wire logic [ifd_pkg::IFD_WORD_W-1:0] mem_rdata,
  input wire ifd_pkg::ifd_exec_t exec_out,
  input wire logic [ifd_pkg::IFD_BANK_W-1:0] upper_bank_extension,
  input wire logic [ifd_pkg::IFD_BANK_W-1:0] lower_bank_extension
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a word accepted during a live fetch, and its indirection flag
  wire logic take = mem_ack && mem_out.req;
  wire logic ind = mem_rdata[14];
  valid_one_cycle_a:
    assert property (exec_out.valid |=> !exec_out.valid) else $error("valid held too long");
  fetch_start_a:
    assert property (fetch_req && !fetch_busy |=> mem_out.req && fetch_busy
      && mem_out.addr == $past(fetch_addr)) else $error("fetch not launched");
  req_hold_a:
    assert property (mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr))
      else $error("memory request dropped");
  next_level_a:
    assert property (take && ind |=> mem_out.req && !exec_out.valid) else $error("chain cut");
  chain_end_a:
    assert property (take && !ind |=> exec_out.valid && !mem_out.req && !fetch_busy)
      else $error("chain not ended");
  direct_map_a:
    assert property (take && ind && !mem_rdata[22] && !mem_rdata[13]
      |=> mem_out.addr == {1'b0, $past(mem_rdata[13:0])}) else $error("low address mapped");
  plain_ea_a:
    assert property (take && !ind && !mem_rdata[22]
      |=> exec_out.eff_addr == $past(mem_rdata[13:0])) else $error("unindexed address wrong");
  pop_flag_a:
    assert property (exec_out.valid |-> exec_out.pop == exec_out.opcode[6])
      else $error("pop flag wrong");
  valid_cause_a:
    assert property (exec_out.valid |-> $past(take)) else $error("valid without final word");
  bank_preset_a:
    assert property (operator_start |=> upper_bank_extension == IFD_UPPER_RESET
      && lower_bank_extension == IFD_LOWER_RESET) else $error("banks not preset");
endmodule : ifd_checker

bind ifd_decoder ifd_checker ifd_checker_i (.pclk, .presetn, .operator_start, .fetch_req,
  .fetch_addr, .fetch_busy, .mem_out, .mem_ack, .mem_rdata, .exec_out,
  .upper_bank_extension, .lower_bank_extension);

// ===== tb/ifd_mem_model.sv
`timescale 1ns/1ps
module ifd_mem_model
  import ifd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire ifd_pkg::ifd_mem_req_t mem_out,
  input wire logic [1:0] delay,
  output logic mem_ack,
  output logic [ifd_pkg::IFD_WORD_W-1:0] mem_rdata
);
  logic [IFD_WORD_W-1:0] mem [0:32767];
  logic [1:0] cnt;
  // read-only core, delay wait states; stale data toggles so it never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 24'h00_0000;
      cnt <= 2'h0;
    end else if (mem_out.req && !mem_ack && cnt == delay) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_out.addr];
      cnt <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_out.req && !mem_ack) cnt <= cnt + 2'h1;
    end
  end
endmodule : ifd_mem_model

// ===== tb/instr_field_decode_eff_addr_tb_top.sv
`timescale 1ns/1ps
module instr_field_decode_eff_addr_tb_top;
  import ifd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic operator_start = 1'b0;
  logic fetch_req = 1'b0;
  logic [14:0] fetch_addr = 15'h0;
  logic fetch_busy;
  ifd_mem_req_t mem_out;
  logic mem_ack;
  logic [23:0] mem_rdata;
  ifd_exec_t exec_out;
  logic [2:0] upper_bank_extension;
  logic [2:0] lower_bank_extension;
  logic [1:0] delay = 2'h0;
  logic [23:0] idx = 24'h00_0000;
  logic [5:0] bank = 6'h13;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #12.5 pclk = ~pclk;

  ifd_decoder ifd_decoder_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .operator_start, .fetch_req, .fetch_addr, .fetch_busy,
    .mem_out, .mem_ack, .mem_rdata, .exec_out, .upper_bank_extension, .lower_bank_extension);
  ifd_mem_model ifd_mem_model_i (.pclk, .presetn, .mem_out, .delay, .mem_ack, .mem_rdata);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("FAIL pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // memory address of an effective address under bank settings b
  function automatic logic [14:0] map(input logic [13:0] e, input logic [5:0] b);
    if (!e[13]) return {1'b0, e};
    return {e[12] ? b[2:0] : b[5:3], e[11:0]};
  endfunction : map

  // walks the chain in the core image, then fetches and compares
  task automatic run(input logic [14:0] a);
    logic [23:0] w;
    logic [13:0] e;
    logic [6:0] op;
    int n;
    int cyc;
    logic [31:0] rd;
    logic err;
    w = ifd_mem_model_i.mem[a];
    op = w[21:15];
    for (n = 1; n < 9; n++) begin
      e = w[13:0] + (w[22] ? idx[13:0] : 14'h0000);
      if (!w[14]) break;
      w = ifd_mem_model_i.mem[map(e, bank)];
    end
    if (n >= 9) return;
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge pclk);
    fetch_req <= 1'b0;
    cyc = 1;
    while (exec_out.valid !== 1'b1 && cyc < 100) begin
      @(posedge pclk);
      cyc++;
    end
    chk("cycles", n * (delay + 2) + 2, cyc);
    chk("opcode", op, exec_out.opcode);
    chk("pop", op[6], exec_out.pop);
    chk("eff addr", e, exec_out.eff_addr);
    chk("mem addr", map(e, bank), exec_out.mem_addr);
    chk("busy", 1'b0, fetch_busy);
    apb(1'b0, IFD_OFS_STATUS, 32'h0, rd, err);
    chk("levels", n - 1, rd[15:8]);
    chk("status op", op, rd[22:16]);
    apb(1'b0, IFD_OFS_RESULT, 32'h0, rd, err);
    chk("result", {1'b0, e, 1'b0, op[6], map(e, bank)}, rd);
  endtask : run

  // hang guard, about four times the expected run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic err;
    logic [23:0] v;
    logic [23:0] w;
    logic [14:0] a;
    logic [14:0] t;
    int lv;
    void'($urandom(32'h62eb_36c7));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, IFD_OFS_BANK, 32'h0, rd, err);
    chk("bank reset", 32'h0000_0013, rd);
    apb(1'b0, 8'h40, 32'h0, rd, err);
    chk("unmapped error", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    $display("test registers done");
    apb(1'b1, IFD_OFS_INDEX, 32'h0000_0001, rd, err);
    idx = 24'h00_0001;
    ifd_mem_model_i.mem[15'h0100] = 24'h40_3fff;
    run(15'h0100);
    $display("test index wrap done");
    apb(1'b1, IFD_OFS_FIXED, 32'h0080_0000, rd, err);
    apb(1'b0, IFD_OFS_FIXNEG, 32'h0, rd, err);
    chk("fixneg min", 32'h0380_0000, rd);
    apb(1'b0, IFD_OFS_FIXED, 32'h0, rd, err);
    chk("fixed sign", 32'h0080_0000, rd);
    // random banks, index, fixed value and chains of up to three levels
    for (int i = 0; i < 150; i++) begin
      bank = 6'($urandom);
      idx = 24'($urandom);
      v = 24'($urandom);
      delay <= 2'($urandom);
      apb(1'b1, IFD_OFS_BANK, {26'h0, bank}, rd, err);
      apb(1'b1, IFD_OFS_INDEX, {8'h00, idx}, rd, err);
      apb(1'b1, IFD_OFS_FIXED, {8'h00, v}, rd, err);
      apb(1'b0, IFD_OFS_BANK, 32'h0, rd, err);
      chk("bank", {26'h0, bank}, rd);
      apb(1'b0, IFD_OFS_FIXNEG, 32'h0, rd, err);
      chk("fixneg", {6'h00, v == 24'h80_0000, v[23], -v}, rd);
      lv = $urandom_range(3);
      a = 15'($urandom);
      t = a;
      for (int k = 0; k <= lv; k++) begin
        w = 24'($urandom);
        w[14] = (k < lv);
        ifd_mem_model_i.mem[t] = w;
        t = map(w[13:0] + (w[22] ? idx[13:0] : 14'h0000), bank);
      end
      run(a);
    end
    $display("test random fetch done");
    apb(1'b1, IFD_OFS_BANK, 32'h0000_003f, rd, err);
    apb(1'b0, IFD_OFS_STATUS, 32'h0, rd, err);
    chk("bank lights", 32'h0000_0006, rd & 32'h0000_0006);
    // start held across a bank write: the preset must win
    operator_start <= 1'b1;
    apb(1'b1, IFD_OFS_BANK, 32'h0000_002d, rd, err);
    operator_start <= 1'b0;
    @(posedge pclk);
    chk("upper bank", 32'h3, upper_bank_extension);
    apb(1'b0, IFD_OFS_BANK, 32'h0, rd, err);
    chk("bank start", 32'h0000_0013, rd);
    $display("test operator start done");
    print_verdict();
  end
endmodule : instr_field_decode_eff_addr_tb_top
